//--- bench/arsx_alu_bench.sv
// arsx_alu_bench: self-checking bench for the alu block over apb
// assumes a 40 ns pclk and the register map of arsx_pkg
`timescale 1ns/100ps
module arsx_alu_bench
  import arsx_pkg::*;
;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic busy;
  logic [31:0] rv;
  logic re;
  logic bz;
  int n_errors;
  int comparisons;

  arsx_alu u_dut (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .busy(busy)
  );

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task test_done;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rv = prdata;
    re = pslverr;
    bz = busy;
    if (i == 20) begin
      n_errors++;
      test_done();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0);
  endtask

  // expected {status, result} of one instruction
  function automatic logic [10:0] model(arsx_op_e op, logic [7:0] l,
      logic [7:0] a, logic [7:0] f, logic [2:0] s);
    logic [7:0] r;
    r = a;
    case (op)
      ARSX_OP_ROTATE_RIGHT_THROUGH_CARRY: begin
        r = {s[ARSX_C_BIT], f[7:1]};
        s[ARSX_C_BIT] = f[0];
      end
      ARSX_OP_SUBTRACT_ACC_FROM_LITERAL: begin
        r = l - a;
        s[ARSX_C_BIT] = a <= l;
        s[ARSX_DC_BIT] = a[3:0] <= l[3:0];
      end
      ARSX_OP_SUBTRACT_ACC_FROM_FILE: begin
        r = f - a;
        s[ARSX_C_BIT] = a <= f;
        s[ARSX_DC_BIT] = a[3:0] <= f[3:0];
      end
      ARSX_OP_XOR_LITERAL_INTO_ACC: r = a ^ l;
      ARSX_OP_XOR_ACC_WITH_FILE: r = a ^ f;
      ARSX_OP_NIBBLE_EXCHANGE: r = {f[3:0], f[7:4]};
      default: r = a;
    endcase
    if (op >= ARSX_OP_SUBTRACT_ACC_FROM_LITERAL &&
        op <= ARSX_OP_XOR_ACC_WITH_FILE) begin
      s[ARSX_Z_BIT] = r == 8'h00;
    end
    return {s, r};
  endfunction

  // load operands, issue one instruction, read back acc, file, status
  task automatic run_op(arsx_op_e op, logic [7:0] l, logic [6:0] fa,
      logic d, logic [7:0] a, logic [7:0] f, logic [2:0] s);
    logic [10:0] e;
    logic [31:0] c;
    logic to_f;
    e = model(op, l, a, f, s);
    to_f = d && op != ARSX_OP_SUBTRACT_ACC_FROM_LITERAL &&
           op != ARSX_OP_XOR_LITERAL_INTO_ACC;
    c = 32'h0;
    c[ARSX_OP_LSB +: 3] = op;
    c[ARSX_DST_BIT] = d;
    c[ARSX_FA_LSB +: 7] = fa;
    c[ARSX_LIT_LSB +: 8] = l;
    wr(ARSX_ACC_OFS, {24'h0, a});
    wr(ARSX_FADDR_OFS, {25'h0, fa});
    wr(ARSX_FDATA_OFS, {24'h0, f});
    wr(ARSX_STAT_OFS, {29'h0, s});
    wr(ARSX_CTRL_OFS, c);
    chk({31'h0, bz}, 32'h1);
    rd(ARSX_ACC_OFS);
    chk(rv, {24'h0, to_f ? a : e[7:0]});
    rd(ARSX_FDATA_OFS);
    chk(rv, {24'h0, to_f ? e[7:0] : f});
    rd(ARSX_STAT_OFS);
    chk(rv, {29'h0, e[10:8]});
    rd(ARSX_CTRL_OFS);
    chk(rv, c);
  endtask

  task t_reset;
    rd(ARSX_ACC_OFS);
    chk(rv, {24'h0, ARSX_ACC_RST});
    chk({31'h0, bz}, 32'h0);
    rd(ARSX_STAT_OFS);
    chk(rv, {29'h0, ARSX_STAT_RST});
    rd(12'h018);
    chk({re, rv[30:0]}, 32'h80000000);
    rd(ARSX_FILE_OFS);
    chk({31'h0, re}, 32'h0);
    $display("test reset done");
  endtask

  task t_rotate;
    run_op(ARSX_OP_ROTATE_RIGHT_THROUGH_CARRY, 8'hff, 7'h05, 1'b1, 8'h3c,
           8'h81, 3'h5);
    run_op(ARSX_OP_ROTATE_RIGHT_THROUGH_CARRY, 8'h00, 7'h7f, 1'b0, 8'h3c,
           8'h02, 3'h6);
    run_op(ARSX_OP_ROTATE_RIGHT_THROUGH_CARRY, 8'h00, 7'h00, 1'b1, 8'h00,
           8'h01, 3'h0);
    $display("test rotate done");
  endtask

  task automatic t_sub;
    logic [7:0] ta [6] = '{8'h05, 8'h06, 8'h1f, 8'h00, 8'hff, 8'h10};
    logic [7:0] tb [6] = '{8'h05, 8'h05, 8'h20, 8'hff, 8'h00, 8'h0f};
    for (int i = 0; i < 6; i++) begin
      run_op(ARSX_OP_SUBTRACT_ACC_FROM_LITERAL, tb[i], 7'h01, i[0], ta[i],
             8'h55, i[0] ? 3'h7 : 3'h0);
      run_op(ARSX_OP_SUBTRACT_ACC_FROM_FILE, 8'h00, 7'(i + 60), i[0],
             ta[i], tb[i], i[0] ? 3'h0 : 3'h7);
    end
    $display("test subtract done");
  endtask

  task t_xor;
    run_op(ARSX_OP_XOR_LITERAL_INTO_ACC, 8'ha5, 7'h02, 1'b1, 8'ha5,
           8'h11, 3'h3);
    run_op(ARSX_OP_XOR_LITERAL_INTO_ACC, 8'hf0, 7'h02, 1'b0, 8'h0f,
           8'h11, 3'h4);
    run_op(ARSX_OP_XOR_ACC_WITH_FILE, 8'h00, 7'h7f, 1'b1, 8'h5a,
           8'h5a, 3'h3);
    run_op(ARSX_OP_XOR_ACC_WITH_FILE, 8'h00, 7'h03, 1'b0, 8'h5a,
           8'ha5, 3'h4);
    $display("test xor done");
  endtask

  task t_swap;
    run_op(ARSX_OP_NIBBLE_EXCHANGE, 8'h00, 7'h04, 1'b0, 8'h77,
           8'hc3, 3'h7);
    run_op(ARSX_OP_NIBBLE_EXCHANGE, 8'h00, 7'h7e, 1'b1, 8'h77,
           8'h00, 3'h0);
    run_op(ARSX_OP_NIBBLE_EXCHANGE, 8'h00, 7'h08, 1'b1, 8'h00,
           8'h1e, 3'h5);
    $display("test swap done");
  endtask

  task t_nop;
    run_op(ARSX_OP_NONE, 8'h3c, 7'h06, 1'b0, 8'h96, 8'h69, 3'h5);
    run_op(arsx_op_e'(3'h7), 8'hc3, 7'h07, 1'b0, 8'h69, 8'h96, 3'h2);
    $display("test no-op done");
  endtask

  initial begin
    n_errors = 0;
    comparisons = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_rotate();
    t_sub();
    t_xor();
    t_swap();
    t_nop();
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    test_done();
  end
endmodule

//--- include/arsx_mem_if.sv
// arsx_mem_if: port bundle between the alu core and its file memory
// assumes one clock; read data appears one cycle after the address
`timescale 1ns/100ps
interface arsx_mem_if;
  logic [6:0] raddr;
  logic [7:0] rdata;
  logic we;
  logic [6:0] waddr;
  logic [7:0] wdata;
  modport core (output raddr, input rdata, output we, output waddr,
    output wdata);
  modport mem (input raddr, output rdata, input we, input waddr,
    input wdata);
endinterface

//--- include/arsx_pkg.sv
// arsx_pkg: register map, field layout and opcode codes for the alu block
// assumes a 32-bit apb master and a 25 MHz pclk
package arsx_pkg;
  localparam logic [11:0] ARSX_CTRL_OFS = 12'h000;
  localparam logic [11:0] ARSX_ACC_OFS = 12'h004;
  localparam logic [11:0] ARSX_FILE_OFS = 12'h008;
  localparam logic [11:0] ARSX_STAT_OFS = 12'h00c;
  localparam logic [11:0] ARSX_FADDR_OFS = 12'h010;
  localparam logic [11:0] ARSX_FDATA_OFS = 12'h014;
  // ctrl word fields
  localparam int ARSX_LIT_LSB = 0;
  localparam int ARSX_FA_LSB = 8;
  localparam int ARSX_DST_BIT = 15;
  localparam int ARSX_OP_LSB = 16;
  // status word fields
  localparam int ARSX_C_BIT = 0;
  localparam int ARSX_DC_BIT = 1;
  localparam int ARSX_Z_BIT = 2;
  localparam logic [7:0] ARSX_ACC_RST = 8'h00;
  localparam logic [2:0] ARSX_STAT_RST = 3'h0;
  localparam int ARSX_FILE_DEPTH = 128;
  typedef enum logic [2:0] {
    ARSX_OP_NONE = 3'b000,
    ARSX_OP_ROTATE_RIGHT_THROUGH_CARRY = 3'b001,
    ARSX_OP_SUBTRACT_ACC_FROM_LITERAL = 3'b010,
    ARSX_OP_SUBTRACT_ACC_FROM_FILE = 3'b011,
    ARSX_OP_XOR_LITERAL_INTO_ACC = 3'b100,
    ARSX_OP_XOR_ACC_WITH_FILE = 3'b101,
    ARSX_OP_NIBBLE_EXCHANGE = 3'b110
  } arsx_op_e;
  typedef enum logic [1:0] {
    ARSX_ST_IDLE = 2'b00,
    ARSX_ST_READ = 2'b01,
    ARSX_ST_EXEC = 2'b10
  } arsx_st_e;
endpackage

//--- rtl/arsx_alu.sv
// arsx_alu: apb-reached alu execute stage with accumulator and file store
// assumes an apb master at 25 MHz, synchronous inputs
// Summary of operation
// [RL1] rotate right moves file bits toward bit 0 via carry; only carry set.
// [RL2] destination bit 0 sends result to accumulator, 1 to the file reg; the two literal ops write the accumulator for either value.
// [RL3] literal minus accumulator into accumulator; carry, half carry, zero.
// [RL4] file minus accumulator to destination; carry, half carry, zero.
// [RL5] accumulator xor literal into accumulator; only zero updates.
// [RL6] nibble exchange swaps file nibbles to destination; flags kept.
// [RL7] accumulator xor file to destination; only zero updates.
// [RL8] zero flag, when updated, is one exactly when the result is zero.
//
// Design decisions made here: the APB slave port and the address map.
`timescale 1ns/100ps
module arsx_alu
  import arsx_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic busy
);
  arsx_mem_if mif ();
  arsx_file_mem u_mem (
    .pclk(pclk),
    .mif(mif)
  );

  arsx_st_e st_r, st_nxt;
  arsx_op_e op_r, op_nxt;
  logic [7:0] lit_r, lit_nxt;
  logic [6:0] fa_r, fa_nxt;
  logic dst_r, dst_nxt;
  logic [7:0] acc_r, acc_nxt;
  logic c_r, c_nxt;
  logic dc_r, dc_nxt;
  logic z_r, z_nxt;
  logic [6:0] dbg_a_r, dbg_a_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;
  logic busy_r, busy_nxt;
  logic [7:0] res;
  logic c_out, dc_out, upd_c, upd_dc, upd_z, to_file_ok;
  logic acc_wr, file_wr;
  logic [7:0] fdata_wr;
  logic setup, known, op_ok;
  logic quiet_r, quiet_nxt;

  arsx_result u_res (
    .op(op_r),
    .acc(acc_r),
    .lit(lit_r),
    .fval(mif.rdata),
    .carry_in(c_r),
    .res(res),
    .c_out(c_out),
    .dc_out(dc_out),
    .upd_c(upd_c),
    .upd_dc(upd_dc),
    .upd_z(upd_z),
    .to_file_ok(to_file_ok)
  );

  assign setup = psel && !penable;
  assign known = (paddr == ARSX_CTRL_OFS) || (paddr == ARSX_ACC_OFS) ||
    (paddr == ARSX_FILE_OFS) || (paddr == ARSX_STAT_OFS) ||
    (paddr == ARSX_FADDR_OFS) || (paddr == ARSX_FDATA_OFS);
  assign op_ok = (op_r != ARSX_OP_NONE) &&
    (op_r <= ARSX_OP_NIBBLE_EXCHANGE);

  // write steering for the executed instruction
  assign acc_wr = (st_r == ARSX_ST_EXEC) && !(to_file_ok && dst_r); // RL2
  assign file_wr = (st_r == ARSX_ST_EXEC) && to_file_ok && dst_r; // RL2

  always_comb begin
    st_nxt = st_r;
    op_nxt = op_r;
    lit_nxt = lit_r;
    fa_nxt = fa_r;
    dst_nxt = dst_r;
    acc_nxt = acc_r;
    c_nxt = c_r;
    dc_nxt = dc_r;
    z_nxt = z_r;
    dbg_a_nxt = dbg_a_r;
    prdata_nxt = prdata_r;
    pready_nxt = 1'b0;
    pslverr_nxt = 1'b0;
    quiet_nxt = (st_r == ARSX_ST_IDLE);
    fdata_wr = pwdata[7:0];
    mif.we = 1'b0;
    mif.waddr = dbg_a_r;
    mif.wdata = pwdata[7:0];
    mif.raddr = dbg_a_r;
    // core stepping
    unique case (st_r)
      ARSX_ST_IDLE: begin
        mif.raddr = dbg_a_r;
      end
      ARSX_ST_READ: begin
        mif.raddr = fa_r;
        st_nxt = ARSX_ST_EXEC;
      end
      ARSX_ST_EXEC: begin
        mif.raddr = fa_r;
        if (acc_wr && op_ok) begin
          acc_nxt = res; // RL2
        end
        if (file_wr) begin
          mif.we = 1'b1;
          mif.waddr = fa_r;
          mif.wdata = res; // RL2
        end
        if (upd_c) begin
          c_nxt = c_out; // RL1
        end
        if (upd_dc) begin
          dc_nxt = dc_out; // RL3
        end
        if (upd_z) begin
          z_nxt = (res == 8'h00); // RL8
        end
        st_nxt = ARSX_ST_IDLE;
      end
      default: begin
        st_nxt = ARSX_ST_IDLE;
      end
    endcase
    // apb slave: take a request once the core has been idle a full cycle
    if (psel && !pready_r && st_r == ARSX_ST_IDLE && quiet_r) begin
      pready_nxt = 1'b1;
      pslverr_nxt = !known;
      if (pwrite) begin
        unique case (paddr)
          ARSX_CTRL_OFS: begin
            lit_nxt = pwdata[ARSX_LIT_LSB +: 8];
            fa_nxt = pwdata[ARSX_FA_LSB +: 7];
            dst_nxt = pwdata[ARSX_DST_BIT];
            op_nxt = arsx_op_e'(pwdata[ARSX_OP_LSB +: 3]);
            st_nxt = ARSX_ST_READ;
          end
          ARSX_ACC_OFS: acc_nxt = pwdata[7:0];
          ARSX_STAT_OFS: begin
            c_nxt = pwdata[ARSX_C_BIT];
            dc_nxt = pwdata[ARSX_DC_BIT];
            z_nxt = pwdata[ARSX_Z_BIT];
          end
          ARSX_FADDR_OFS: dbg_a_nxt = pwdata[6:0];
          ARSX_FDATA_OFS: begin
            mif.we = 1'b1;
            mif.waddr = dbg_a_r;
            mif.wdata = fdata_wr;
          end
          default: pslverr_nxt = !known;
        endcase
        prdata_nxt = 32'h0000_0000;
      end else begin
        unique case (paddr)
          ARSX_CTRL_OFS: prdata_nxt = {13'h0000, op_r, dst_r, fa_r,
            lit_r};
          ARSX_ACC_OFS: prdata_nxt = {24'h00_0000, acc_r};
          ARSX_STAT_OFS: prdata_nxt = {29'h0000_0000, z_r, dc_r, c_r};
          ARSX_FADDR_OFS: prdata_nxt = {25'h000_0000, dbg_a_r};
          ARSX_FDATA_OFS: prdata_nxt = {24'h00_0000, mif.rdata};
          default: prdata_nxt = 32'h0000_0000;
        endcase
      end
    end
    busy_nxt = (st_nxt != ARSX_ST_IDLE);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= ARSX_ST_IDLE;
      op_r <= ARSX_OP_NONE;
      lit_r <= 8'h00;
      fa_r <= 7'h00;
      dst_r <= 1'b0;
      acc_r <= ARSX_ACC_RST;
      c_r <= ARSX_STAT_RST[ARSX_C_BIT];
      dc_r <= ARSX_STAT_RST[ARSX_DC_BIT];
      z_r <= ARSX_STAT_RST[ARSX_Z_BIT];
      dbg_a_r <= 7'h00;
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      busy_r <= 1'b0;
      quiet_r <= 1'b1;
    end else begin
      st_r <= st_nxt;
      op_r <= op_nxt;
      lit_r <= lit_nxt;
      fa_r <= fa_nxt;
      dst_r <= dst_nxt;
      acc_r <= acc_nxt;
      c_r <= c_nxt;
      dc_r <= dc_nxt;
      z_r <= z_nxt;
      dbg_a_r <= dbg_a_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      busy_r <= busy_nxt;
      quiet_r <= quiet_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign busy = busy_r;

  // checks
  logic ex;
  assign ex = (st_r == ARSX_ST_EXEC);
  property p_rot;
    @(posedge pclk) disable iff (!presetn)
    ex && op_r == ARSX_OP_ROTATE_RIGHT_THROUGH_CARRY |=>
      c_r == $past(mif.rdata[0]) && z_r == $past(z_r) &&
      dc_r == $past(dc_r);
  endproperty
  a_rot: assert property (p_rot) else $error("rotate carry wrong"); // RL1
  property p_dst;
    @(posedge pclk) disable iff (!presetn)
    ex && op_r == ARSX_OP_XOR_ACC_WITH_FILE && dst_r |=>
      acc_r == $past(acc_r);
  endproperty
  a_dst: assert property (p_dst) else $error("acc hit on file dst"); // RL2
  property p_subl;
    @(posedge pclk) disable iff (!presetn)
    ex && op_r == ARSX_OP_SUBTRACT_ACC_FROM_LITERAL |=>
      acc_r == 8'($past(lit_r) - $past(acc_r)) &&
      c_r == ($past(acc_r) <= $past(lit_r));
  endproperty
  a_subl: assert property (p_subl) else $error("literal subtract"); // RL3
  property p_subf;
    @(posedge pclk) disable iff (!presetn)
    ex && op_r == ARSX_OP_SUBTRACT_ACC_FROM_FILE |=>
      dc_r == ($past(acc_r[3:0]) <= $past(mif.rdata[3:0]));
  endproperty
  a_subf: assert property (p_subf) else $error("file subtract dc"); // RL4
  property p_xorl;
    @(posedge pclk) disable iff (!presetn)
    ex && op_r == ARSX_OP_XOR_LITERAL_INTO_ACC |=>
      acc_r == ($past(acc_r) ^ $past(lit_r)) && c_r == $past(c_r);
  endproperty
  a_xorl: assert property (p_xorl) else $error("literal xor"); // RL5
  property p_swap;
    @(posedge pclk) disable iff (!presetn)
    ex && op_r == ARSX_OP_NIBBLE_EXCHANGE |=> $stable({c_r, dc_r, z_r});
  endproperty
  a_swap: assert property (p_swap) else $error("swap moved flags"); // RL6
  property p_xorf;
    @(posedge pclk) disable iff (!presetn)
    ex && op_r == ARSX_OP_XOR_ACC_WITH_FILE && !dst_r |=>
      acc_r == ($past(acc_r) ^ $past(mif.rdata)) && dc_r == $past(dc_r);
  endproperty
  a_xorf: assert property (p_xorf) else $error("file xor"); // RL7
  property p_zero;
    @(posedge pclk) disable iff (!presetn)
    ex && upd_z |=> z_r == ($past(res) == 8'h00);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong"); // RL8
  property p_ans;
    @(posedge pclk) disable iff (!presetn)
    setup && !busy_r |=> ##[0:3] pready_r;
  endproperty
  a_ans: assert property (p_ans) else $error("no apb answer");
  property p_rotres;
    @(posedge pclk) disable iff (!presetn)
    ex && op_r == ARSX_OP_ROTATE_RIGHT_THROUGH_CARRY && !dst_r |=>
      acc_r == {$past(c_r), $past(mif.rdata[7:1])};
  endproperty
  a_rotres: assert property (p_rotres) else $error("rotate value"); // RL1
  property p_swapres;
    @(posedge pclk) disable iff (!presetn)
    ex && op_r == ARSX_OP_NIBBLE_EXCHANGE && !dst_r |=>
      acc_r == {$past(mif.rdata[3:0]), $past(mif.rdata[7:4])};
  endproperty
  a_swapres: assert property (p_swapres) else $error("swap value"); // RL6
  property p_filew;
    @(posedge pclk) disable iff (!presetn)
    ex && dst_r && op_r == ARSX_OP_SUBTRACT_ACC_FROM_FILE |->
      mif.we && mif.waddr == fa_r && mif.wdata == 8'(mif.rdata - acc_r);
  endproperty
  a_filew: assert property (p_filew) else $error("file subtract store"); // RL4
  property p_nop;
    @(posedge pclk) disable iff (!presetn)
    ex && !op_ok |=> acc_r == $past(acc_r) &&
      {c_r, dc_r, z_r} == $past({c_r, dc_r, z_r});
  endproperty
  a_nop: assert property (p_nop) else $error("no-op changed state");
  property p_err;
    @(posedge pclk) disable iff (!presetn)
    pslverr_r |-> pready_r;
  endproperty
  a_err: assert property (p_err) else $error("error without ready");
  c_nop: cover property (@(posedge pclk) ex && !op_ok);
  c_rot: cover property (@(posedge pclk) ex && upd_c && !upd_z);
  c_sub: cover property (@(posedge pclk) ex && upd_dc && c_out);
  c_fw: cover property (@(posedge pclk) file_wr);
endmodule

//--- rtl/arsx_file_mem.sv
// arsx_file_mem: 128 by 8 file register store, registered read data
// assumes single clock; write and read ports independent
`timescale 1ns/100ps
module arsx_file_mem
  import arsx_pkg::*;
#(
  parameter int DEPTH = ARSX_FILE_DEPTH
) (
  input wire logic pclk,
  arsx_mem_if.mem mif
);
  logic [7:0] mem_r [DEPTH];
  logic [7:0] rdata_r;
  always_ff @(posedge pclk) begin
    if (mif.we) begin
      mem_r[mif.waddr] <= mif.wdata;
    end
    rdata_r <= mem_r[mif.raddr];
  end
  assign mif.rdata = rdata_r;
endmodule

//--- rtl/arsx_result.sv
// arsx_result: combinational result and flag unit for six instructions
// assumes operands stable for the cycle in which the result is used
`timescale 1ns/100ps
module arsx_result
  import arsx_pkg::*;
(
  input wire arsx_op_e op,
  input wire logic [7:0] acc,
  input wire logic [7:0] lit,
  input wire logic [7:0] fval,
  input wire logic carry_in,
  output logic [7:0] res,
  output logic c_out,
  output logic dc_out,
  output logic upd_c,
  output logic upd_dc,
  output logic upd_z,
  output logic to_file_ok
);
  logic [7:0] sub_a;
  always_comb begin
    sub_a = (op == ARSX_OP_SUBTRACT_ACC_FROM_LITERAL) ? lit : fval;
    res = 8'h00;
    c_out = 1'b0;
    dc_out = 1'b0;
    upd_c = 1'b0;
    upd_dc = 1'b0;
    upd_z = 1'b0;
    to_file_ok = 1'b0;
    unique case (op)
      ARSX_OP_ROTATE_RIGHT_THROUGH_CARRY: begin
        res = {carry_in, fval[7:1]}; // RL1
        c_out = fval[0]; // RL1
        upd_c = 1'b1;
        to_file_ok = 1'b1;
      end
      ARSX_OP_SUBTRACT_ACC_FROM_LITERAL,
      ARSX_OP_SUBTRACT_ACC_FROM_FILE: begin
        res = sub_a - acc; // RL3 RL4
        c_out = (acc <= sub_a); // RL3 RL4
        dc_out = (acc[3:0] <= sub_a[3:0]); // RL3 RL4
        upd_c = 1'b1;
        upd_dc = 1'b1;
        upd_z = 1'b1;
        to_file_ok = (op == ARSX_OP_SUBTRACT_ACC_FROM_FILE);
      end
      ARSX_OP_XOR_LITERAL_INTO_ACC: begin
        res = acc ^ lit; // RL5
        upd_z = 1'b1;
      end
      ARSX_OP_XOR_ACC_WITH_FILE: begin
        res = acc ^ fval; // RL7
        upd_z = 1'b1;
        to_file_ok = 1'b1;
      end
      ARSX_OP_NIBBLE_EXCHANGE: begin
        res = {fval[3:0], fval[7:4]}; // RL6
        to_file_ok = 1'b1;
      end
      default: begin
        res = 8'h00;
      end
    endcase
  end
endmodule
